// File: bench/rtcswt_host.sv
`timescale 1ns/1ps
module rtcswt_host (
  input wire logic clk,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n,
  output logic [16:0] addr,
  output logic [7:0] dq_in,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  initial
  begin
    addr = 17'h00000;
    dq_in = 8'h00;
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
  end

  // Every pin change lands just after a rising edge
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : gap

  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    addr = a;
    dq_in = d;
    ce_n = 1'b0;
    we_n = 1'b0;
    gap(6);
    ce_n = 1'b1;
    we_n = 1'b1;
    // Address and data held past the strobe for the synchronisers
    gap(4);
    // Released bus shows the inverse of the last byte
    dq_in = ~d;
    gap(2);
  endtask : wr

  task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic drove);
    int n;
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    drove = 1'b0;
    d = 8'h00;
    // Sample just after the edge, once the registered outputs have settled
    for (n = 0; n < 8 && !drove; n++)
    begin
      @(posedge clk);
      #1;
      drove = (dq_oe_n === 1'b0);
      d = dq_out;
    end
    ce_n = 1'b1;
    oe_n = 1'b1;
    gap(6);
  endtask : rd
endmodule : rtcswt_host

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rtcswt_pkg::*;
  localparam int TICK = 64;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic irq_en = 1'b0;
  logic flag_clr = 1'b0;
  logic [16:0] addr;
  logic [7:0] dq_in, dq_out, v;
  logic dq_oe_n, ce_n, we_n, oe_n, flag, irq, carry;
  logic [5:0] t1;
  logic [16:0] offs [4] = '{OFF_WATCHDOG_CONTROL, OFF_OSCILLATOR_TRIM, OFF_CLOCK_SECONDS,
    OFF_CLOCK_MINUTES};
  logic [7:0] trims [4] = '{8'h3f, 8'h1f, 8'h00, 8'h80};
  int mismatches = 0;
  int comparisons = 0;
  int n;

  always #5 clk_sys = ~clk_sys;

  rtcswt_top #(.TICK_CYCLES_P(TICK), .CAL_STEP_P(1)) dut (.CLK_SYS(clk_sys), .RESET_N(reset_n),
    .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .CHIP_EN_N(ce_n),
    .WRITE_EN_N(we_n), .OUTPUT_EN_N(oe_n), .WATCHDOG_IRQ_ENABLE(irq_en),
    .WATCHDOG_FLAG_CLEAR(flag_clr), .WATCHDOG_EXPIRED_FLAG(flag), .WATCHDOG_IRQ(irq),
    .HOURS_CARRY(carry));
  rtcswt_host host (.clk(clk_sys), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .addr(addr),
    .dq_in(dq_in), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));

  function automatic logic [7:0] bcd(input int k);
    return {4'(k / 10), 4'(k % 10)};
  endfunction : bcd

  // Whole seconds elapsed for a trim setting, or none while stopped
  function automatic logic [7:0] secs_after(input logic [7:0] trim, input int cyc);
    int per;
    per = trim[5] ? TICK - int'(trim[4:0]) : TICK + int'(trim[4:0]);
    return trim[7] ? 8'h00 : bcd(cyc / (32 * per));
  endfunction : secs_after

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic rchk(input logic [16:0] a, input logic [7:0] exp, input logic drv = 1'b1);
    logic [7:0] d;
    logic drove;
    host.rd(a, d, drove);
    check({7'h00, drove}, {7'h00, drv});
    check(d, exp);
  endtask : rchk

  task automatic wait_hi(input logic sel, input int lim);
    for (n = 0; n < lim && (sel ? carry : flag) !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask : wait_hi

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end

  initial
  begin
    void'($urandom(55));
    repeat (10) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    host.gap(1);
    foreach (offs[i])
      rchk(offs[i], 8'h00);
    rchk(17'h1fff6, 8'h00, 1'b0);
    repeat (4)
    begin
      v = 8'h80 | 8'($urandom_range(127));
      host.wr(OFF_OSCILLATOR_TRIM, v);
      rchk(OFF_OSCILLATOR_TRIM, v & 8'hbf);
      v = bcd($urandom_range(59));
      host.wr(OFF_CLOCK_SECONDS, v | 8'h80);
      rchk(OFF_CLOCK_SECONDS, v);
      v = bcd($urandom_range(59));
      host.wr(OFF_CLOCK_MINUTES, v | 8'h80);
      rchk(OFF_CLOCK_MINUTES, v);
    end
    t1 = 6'($urandom_range(63, 1));
    host.wr(OFF_WATCHDOG_CONTROL, {2'b11, t1});
    rchk(OFF_WATCHDOG_CONTROL, {2'b01, t1});
    host.wr(OFF_WATCHDOG_CONTROL, {2'b01, ~t1});
    rchk(OFF_WATCHDOG_CONTROL, {2'b01, t1});
    host.wr(OFF_WATCHDOG_CONTROL, {2'b00, ~t1});
    rchk(OFF_WATCHDOG_CONTROL, {2'b00, t1});
    host.wr(OFF_WATCHDOG_CONTROL, 8'h83);
    rchk(OFF_WATCHDOG_CONTROL, 8'h03);
    host.wr(OFF_OSCILLATOR_TRIM, 8'h00);
    wait_hi(1'b0, 400);
    check({7'h00, n >= 100 && n <= 200}, 8'h01);
    check({7'h00, irq}, 8'h00);
    irq_en = ~irq_en;
    host.gap(2);
    check({6'h00, flag, irq}, 8'h03);
    host.wr(OFF_WATCHDOG_CONTROL, 8'h80);
    flag_clr = 1'b1;
    host.gap(1);
    flag_clr = 1'b0;
    host.gap(600);
    check({6'h00, flag, irq}, 8'h00);
    // Seconds first: the write restarts the sub-second count, so no carry slips in early
    host.wr(OFF_CLOCK_SECONDS, 8'h59);
    host.wr(OFF_CLOCK_MINUTES, 8'h59);
    wait_hi(1'b1, 2200);
    check({7'h00, n < 2200}, 8'h01);
    rchk(OFF_CLOCK_MINUTES, 8'h00);
    rchk(OFF_CLOCK_SECONDS, 8'h00);
    foreach (trims[i])
    begin
      host.wr(OFF_OSCILLATOR_TRIM, trims[i]);
      host.wr(OFF_CLOCK_SECONDS, 8'h00);
      host.gap(2200);
      rchk(OFF_CLOCK_SECONDS, secs_after(trims[i], 2210));
    end
    stop_test();
  end
endmodule : tb_top

// File: verilog/rtcswt_bcd_inc.sv
`timescale 1ns/1ps
module rtcswt_bcd_inc (
  input wire logic [7:0] value,
  input wire logic [3:0] tens_max,
  output logic [7:0] next,
  output logic wrap
);
  import rtcswt_pkg::*;
  always_comb
  begin
    next = 8'h00;
    wrap = 1'b0;
    if (value[3:0] < BCD_ONES_MAX)
    begin
      next = {1'b0, value[6:4], value[3:0] + 4'h1};
    end
    else if ({1'b0, value[6:4]} < tens_max)
    begin
      next = {1'b0, value[6:4] + 3'h1, 4'h0};
    end
    else
    begin
      wrap = 1'b1;
    end
  end
endmodule : rtcswt_bcd_inc

// File: verilog/rtcswt_pkg.sv
package rtcswt_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [16:0] OFF_WATCHDOG_CONTROL = 17'h1fff7;
  localparam logic [16:0] OFF_OSCILLATOR_TRIM = 17'h1fff8;
  localparam logic [16:0] OFF_CLOCK_SECONDS = 17'h1fff9;
  localparam logic [16:0] OFF_CLOCK_MINUTES = 17'h1fffa;
  localparam int WD_KICK_BIT = 7;
  localparam int WD_LOCK_BIT = 6;
  localparam int TRIM_OFF_BIT = 7;
  localparam int TRIM_SIGN_BIT = 5;
  localparam logic [3:0] BCD_ONES_MAX = 4'h9;
  localparam logic [3:0] SEC_TENS_MAX = 4'h5;
  localparam logic [3:0] MIN_TENS_MAX = 4'h5;
  localparam logic [4:0] TICKS_PER_SECOND_M1 = 5'h1f;
  localparam logic [5:0] TIMEOUT_RESET = 6'h00;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] TIME_RESET = 8'h00;
  localparam longint CLK_PERIOD_PS = 10000;
  localparam longint TICK_PERIOD_PS = 64'd31250000000;
  localparam int TICK_CYCLES = int'(TICK_PERIOD_PS / CLK_PERIOD_PS);
  localparam int CAL_STEP_CYCLES = 16;
endpackage : rtcswt_pkg

// File: verilog/rtcswt_top.sv
`timescale 1ns/1ps
module rtcswt_top #(
  parameter int TICK_CYCLES_P = rtcswt_pkg::TICK_CYCLES,
  parameter int CAL_STEP_P = rtcswt_pkg::CAL_STEP_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [rtcswt_pkg::ADDR_W-1:0] ADDR,
  input wire logic [rtcswt_pkg::DATA_W-1:0] DQ_IN,
  output logic [rtcswt_pkg::DATA_W-1:0] DQ_OUT,
  output logic DQ_OE_N,
  input wire logic CHIP_EN_N,
  input wire logic WRITE_EN_N,
  input wire logic OUTPUT_EN_N,
  input wire logic WATCHDOG_IRQ_ENABLE,
  input wire logic WATCHDOG_FLAG_CLEAR,
  output logic WATCHDOG_EXPIRED_FLAG,
  output logic WATCHDOG_IRQ,
  output logic HOURS_CARRY
);
  import rtcswt_pkg::*;

  initial
  begin
    if (TICK_CYCLES_P <= 32 * CAL_STEP_P || TICK_CYCLES_P >= (1 << 23))
      $error("rtcswt_top: TICK_CYCLES_P out of range for the trim and divider width");
  end

  typedef struct packed {
    logic [2:0] ce_s;
    logic [2:0] we_s;
    logic [2:0] oe_s;
    logic [16:0] addr1;
    logic [16:0] addr2;
    logic [16:0] addr3;
    logic [7:0] din1;
    logic [7:0] din2;
    logic [7:0] din3;
    logic wr_prev;
    logic [22:0] div;
    logic [4:0] sub;
    logic [7:0] sec;
    logic [7:0] min;
    logic osc_off;
    logic cal_sign;
    logic [4:0] cal_mag;
    logic lock;
    logic [5:0] timeout;
    logic [5:0] wd_cnt;
    logic kick;
    logic flag;
    logic irq;
    logic carry;
    logic [7:0] dq_out;
    logic dq_oe_n;
  } rtcswt_state_s;

  rtcswt_state_s q;
  rtcswt_state_s d;
  logic [7:0] sec_next;
  logic sec_wrap;
  logic [7:0] min_next;
  logic min_wrap;
  logic tick;
  logic wr_act;
  logic rd_act;
  logic wr_evt;
  logic [22:0] period_m1;

  rtcswt_bcd_inc u_sec_inc (
    .value(q.sec),
    .tens_max(SEC_TENS_MAX),
    .next(sec_next),
    .wrap(sec_wrap)
  );

  rtcswt_bcd_inc u_min_inc (
    .value(q.min),
    .tens_max(MIN_TENS_MAX),
    .next(min_next),
    .wrap(min_wrap)
  );

  // Adding lengthens the tick period, subtracting shortens it
  always_comb
  begin
    period_m1 = 23'(TICK_CYCLES_P - 1);
    if (q.cal_sign)
      period_m1 = period_m1 - 23'(q.cal_mag * CAL_STEP_P);
    else
      period_m1 = period_m1 + 23'(q.cal_mag * CAL_STEP_P);
  end

  // Synchronised strobes count once stages two and three agree
  assign wr_act = (q.ce_s[1] == q.ce_s[2]) && !q.ce_s[2]
    && (q.we_s[1] == q.we_s[2]) && !q.we_s[2];
  assign rd_act = (q.ce_s[1] == q.ce_s[2]) && !q.ce_s[2]
    && (q.oe_s[1] == q.oe_s[2]) && !q.oe_s[2]
    && (q.we_s[1] == q.we_s[2]) && q.we_s[2];
  assign wr_evt = wr_act && !q.wr_prev;
  assign tick = !q.osc_off && (q.div == 23'h000000);

  always_comb
  begin
    d = q;
    d.ce_s = {q.ce_s[1:0], CHIP_EN_N};
    d.we_s = {q.we_s[1:0], WRITE_EN_N};
    d.oe_s = {q.oe_s[1:0], OUTPUT_EN_N};
    d.addr1 = ADDR;
    d.addr2 = q.addr1;
    d.addr3 = q.addr2;
    d.din1 = DQ_IN;
    d.din2 = q.din1;
    d.din3 = q.din2;
    d.wr_prev = wr_act;
    d.carry = 1'b0;
    if (!q.osc_off)
      d.div = tick ? period_m1 : q.div - 23'h000001;
    if (tick)
    begin
      d.sub = q.sub + 5'h01;
      if (q.sub == TICKS_PER_SECOND_M1)
      begin
        d.sec = sec_next;
        if (sec_wrap)
        begin
          d.min = min_next;
          d.carry = min_wrap;
        end
      end
    end
    if (tick && q.timeout != 6'h00)
    begin
      if (q.wd_cnt <= 6'h01)
      begin
        d.flag = 1'b1;
        d.wd_cnt = q.timeout;
      end
      else
        d.wd_cnt = q.wd_cnt - 6'h01;
    end
    if (q.kick)
    begin
      d.wd_cnt = q.timeout;
      d.kick = 1'b0;
    end
    if (WATCHDOG_FLAG_CLEAR && !d.flag)
      d.flag = 1'b0;
    else if (WATCHDOG_FLAG_CLEAR && q.flag && !(tick && q.timeout != 6'h00
      && q.wd_cnt <= 6'h01))
      d.flag = 1'b0;
    if (wr_evt)
    begin
      case (q.addr3)
        OFF_WATCHDOG_CONTROL:
        begin
          d.kick = q.din3[WD_KICK_BIT];
          if (!q.lock)
            d.timeout = q.din3[5:0];
          d.lock = q.din3[WD_LOCK_BIT];
        end
        OFF_OSCILLATOR_TRIM:
        begin
          d.osc_off = q.din3[TRIM_OFF_BIT];
          d.cal_sign = q.din3[TRIM_SIGN_BIT];
          d.cal_mag = q.din3[4:0];
        end
        OFF_CLOCK_SECONDS:
        begin
          d.sec = {1'b0, q.din3[6:0]};
          d.sub = 5'h00;
        end
        OFF_CLOCK_MINUTES:
          d.min = {1'b0, q.din3[6:0]};
        default:
          d.sub = d.sub;
      endcase
    end
    d.irq = d.flag && WATCHDOG_IRQ_ENABLE;
    d.dq_oe_n = 1'b1;
    d.dq_out = 8'h00;
    if (rd_act)
    begin
      case (q.addr3)
        OFF_WATCHDOG_CONTROL:
        begin
          d.dq_oe_n = 1'b0;
          d.dq_out = {1'b0, q.lock, q.timeout};
        end
        OFF_OSCILLATOR_TRIM:
        begin
          d.dq_oe_n = 1'b0;
          d.dq_out = {q.osc_off, 1'b0, q.cal_sign, q.cal_mag};
        end
        OFF_CLOCK_SECONDS:
        begin
          d.dq_oe_n = 1'b0;
          d.dq_out = q.sec;
        end
        OFF_CLOCK_MINUTES:
        begin
          d.dq_oe_n = 1'b0;
          d.dq_out = {1'b0, q.min[6:0]};
        end
        default:
          d.dq_oe_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      q <= '0;
      q.ce_s <= 3'h7;
      q.we_s <= 3'h7;
      q.oe_s <= 3'h7;
      q.wr_prev <= 1'b0;
      q.sec <= TIME_RESET;
      q.min <= TIME_RESET;
      {q.osc_off, q.cal_sign, q.cal_mag} <= {TRIM_RESET[7], TRIM_RESET[5:0]};
      q.timeout <= TIMEOUT_RESET;
      q.dq_oe_n <= 1'b1;
    end
    else
      q <= d;
  end

  assign DQ_OUT = q.dq_out;
  assign DQ_OE_N = q.dq_oe_n;
  assign WATCHDOG_EXPIRED_FLAG = q.flag;
  assign WATCHDOG_IRQ = q.irq;
  assign HOURS_CARRY = q.carry;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  minutes_bcd_a: assert property ($past(rd_act) && $past(q.addr3) == OFF_CLOCK_MINUTES
    |-> !q.dq_oe_n && q.dq_out == {1'b0, $past(q.min[6:0])})
    else $error("minutes read not the stored digits with bit 7 clear");
  seconds_range_a: assert property (
    $past(tick) && $past(q.sub) == TICKS_PER_SECOND_M1 && !$past(wr_evt)
    |-> q.sec[3:0] <= 4'h9 && q.sec[6:4] <= 3'h5)
    else $error("seconds left BCD range after increment");
  osc_stop_a: assert property (q.osc_off && !$past(q.osc_off) ##1 q.osc_off
    |-> $stable(q.div))
    else $error("divider moved while oscillator is off");
  kick_reload_a: assert property (q.kick |=> q.wd_cnt == $past(q.timeout) && !q.kick)
    else $error("kick did not reload and clear");
  kick_reads_zero_a: assert property (!q.dq_oe_n && $past(q.addr3) == OFF_WATCHDOG_CONTROL
    |-> !q.dq_out[WD_KICK_BIT])
    else $error("kick bit read back as one");
  lock_holds_a: assert property (q.lock |=> $stable(q.timeout))
    else $error("timeout changed while locked");
  disabled_wd_a: assert property (q.timeout == 6'h00 && !q.flag |=> !q.flag)
    else $error("disabled watchdog expired");
  irq_gate_a: assert property (WATCHDOG_IRQ == (q.flag && $past(WATCHDOG_IRQ_ENABLE)))
    else $error("interrupt not gated by enable");
  hour_carry_a: assert property (q.carry |-> $past(q.min) == 8'h59 && $past(q.sec) == 8'h59)
    else $error("hours carry without 59:59");
  wd_countdown_a: assert property (tick && q.timeout != 6'h00 && q.wd_cnt > 6'h01
    && !q.kick |=> q.wd_cnt == $past(q.wd_cnt) - 6'h01)
    else $error("watchdog did not count down");

  expiry_c: cover property (!q.flag ##1 q.flag);
  carry_c: cover property (q.carry);
  kick_c: cover property (q.kick ##1 !q.kick);
  timeout_write_c: cover property (!q.lock ##1 $changed(q.timeout));
endmodule : rtcswt_top
